/* core/dpcfg_defines.svh */
// register map, field positions, reset values and scaling constants
`ifndef DPCFG_DEFINES_SVH
`define DPCFG_DEFINES_SVH

`define DPCFG_ADDR_BUILD_OUT    8'h72
`define DPCFG_ADDR_FINE_LOSS    8'h73

`define DPCFG_RST_BUILD_OUT     8'h00
`define DPCFG_RST_FINE_LOSS     8'ha2

`define DPCFG_BO_MSB            5
`define DPCFG_FL_EN_BIT         7
`define DPCFG_FL_NOACT_BIT      6
`define DPCFG_FL_NARROW_BIT     5
`define DPCFG_FL_LIM_MSB        2

`define DPCFG_PHASE_W           16
// phase units per offset step and per fine limit step
`define DPCFG_BO_STEP           16'h0010
`define DPCFG_FINE_STEP         16'h0400

`endif

/* core/dpcfg_fine_window.sv */
// fine phase-loss window comparator
`timescale 1ns/1ps
`include "dpcfg_defines.svh"
module dpcfg_fine_window (
	input  wire logic                  sys_clk,    // system clock
	input  wire logic                  rst_n,      // synchronised reset
	input  wire logic                  enable,     // fine limit in use
	input  wire dpcfg_pkg::dpcfg_limit_t limit,    // window code
	input  wire dpcfg_pkg::dpcfg_phase_t phase_err, // measured phase error
	output logic                       exceed      // error outside window
);
	import dpcfg_pkg::*;

	function automatic logic [15:0] dpcfg_abs(input dpcfg_phase_t v);
		dpcfg_abs = v[15] ? 16'(-v) : 16'(v);
	endfunction

	wire logic [31:0] window_w;
	wire logic        over_w;

	// window grows in proportion to the code
	assign window_w = 32'(limit) * 32'(`DPCFG_FINE_STEP);
	assign over_w   = {16'h0000, dpcfg_abs(phase_err)} > window_w;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			exceed <= 1'b0;
		end else begin
			exceed <= enable & over_w;
		end
	end
endmodule

/* core/dpcfg_pkg.sv */
// types shared by the phase build-out and phase-loss configuration block
package dpcfg_pkg;
	typedef logic signed [15:0] dpcfg_phase_t;
	typedef logic [2:0]         dpcfg_limit_t;
	typedef enum logic [1:0] {
		DPCFG_LOCKED,
		DPCFG_HOLDING,
		DPCFG_LOST
	} dpcfg_lock_t;
endpackage

/* core/dpcfg_top.sv */
// build-out time offset and fine phase-loss configuration for a DPLL
// How it works
// - every build-out event has the 6-bit signed offset added to it
// - zero offset leaves the event error untouched so mean stays zero
// - bit 7 of the phase-loss register enables the 3-bit fine limit
// - enable clear: only other detectors and inactivity loss (bit 6 set) raise phase loss
// - enable set: loss flagged when error exceeds the programmed window
// - inactivity loss clear: hold lock, relock to nearest edge on return
// - phase-loss register resets to 1010 0010
`timescale 1ns/1ps
`include "dpcfg_defines.svh"
module dpcfg_top (
	input  wire logic                   sys_clk,        // 100 MHz clock
	input  wire logic                   resetn,         // power-on reset
	input  wire logic [7:0]             up_addr,        // register address
	input  wire logic                   up_wr,          // write strobe
	input  wire logic                   up_rd,          // read strobe
	input  wire logic [7:0]             up_wdata,       // write data
	output logic      [7:0]             up_rdata,       // read data
	input  wire logic                   bo_event,       // build-out event
	input  wire dpcfg_pkg::dpcfg_phase_t bo_phase_in,   // event phase error
	output dpcfg_pkg::dpcfg_phase_t     bo_phase_out,   // offset-corrected
	output logic                        bo_valid,       // corrected valid
	input  wire dpcfg_pkg::dpcfg_phase_t phase_err,     // detector error
	input  wire logic                   src_active,     // input has edges
	input  wire logic                   other_loss,     // other detectors
	output logic                        phase_lost,     // phase loss flag
	output logic                        relock_nearest, // relock pulse
	output dpcfg_pkg::dpcfg_phase_t     relock_adjust,  // nearest-edge step
	output logic                        narrow_test     // test bit level
);
	import dpcfg_pkg::*;

	// address decode shared by the write and read paths
	function automatic logic dpcfg_hit(input logic [7:0] addr,
		input logic [7:0] reg_addr);
		dpcfg_hit = addr == reg_addr;
	endfunction

	// sign-extend a 6-bit step count and scale it into phase units
	function automatic dpcfg_phase_t dpcfg_scale(input logic [5:0] steps);
		dpcfg_scale = 16'($signed(steps) * $signed(`DPCFG_BO_STEP));
	endfunction

	// two's complement step that moves the loop onto the nearest edge
	function automatic dpcfg_phase_t dpcfg_negate(input dpcfg_phase_t v);
		dpcfg_negate = 16'(-v);
	endfunction

	logic rst_s1_q;
	logic rst_n;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	logic [5:0] bo_offset_q;
	logic [7:0] fine_cfg_q;

	wire logic hit_bo_w;
	wire logic hit_fl_w;
	wire logic fl_enable_w;
	wire logic noact_loss_w;
	wire dpcfg_limit_t fl_limit_w;
	wire logic [7:0] rd_mux_w;
	wire logic wr_bo_w;
	wire logic wr_fl_w;

	assign hit_bo_w     = dpcfg_hit(up_addr, `DPCFG_ADDR_BUILD_OUT);
	assign hit_fl_w     = dpcfg_hit(up_addr, `DPCFG_ADDR_FINE_LOSS);
	// writes land at the edge that samples the strobe
	assign wr_bo_w      = up_wr & hit_bo_w;
	assign wr_fl_w      = up_wr & hit_fl_w;
	assign fl_enable_w  = fine_cfg_q[`DPCFG_FL_EN_BIT];
	assign noact_loss_w = fine_cfg_q[`DPCFG_FL_NOACT_BIT];
	assign fl_limit_w   = fine_cfg_q[`DPCFG_FL_LIM_MSB:0];
	// unused offset bits read zero, unmapped addresses read zero
	assign rd_mux_w = hit_bo_w ? {2'b00, bo_offset_q} :
		hit_fl_w ? fine_cfg_q : 8'h00;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bo_offset_q <= 6'(`DPCFG_RST_BUILD_OUT);
		end else if (wr_bo_w) begin
			bo_offset_q <= up_wdata[`DPCFG_BO_MSB:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fine_cfg_q <= `DPCFG_RST_FINE_LOSS;
		end else if (wr_fl_w) begin
			fine_cfg_q <= up_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_rdata <= 8'h00;
		end else if (up_rd) begin
			up_rdata <= rd_mux_w;
		end
	end

	// test bit is mirrored on its own output
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			narrow_test <= 1'b1;
		end else begin
			narrow_test <= fine_cfg_q[`DPCFG_FL_NARROW_BIT];
		end
	end

	// offset is a signed step count scaled into phase units
	wire dpcfg_phase_t bo_scaled_w;
	wire dpcfg_phase_t bo_sum_w;

	assign bo_scaled_w = dpcfg_scale(bo_offset_q);
	assign bo_sum_w    = bo_phase_in + bo_scaled_w;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bo_phase_out <= 16'h0000;
			bo_valid     <= 1'b0;
		end else begin
			bo_valid <= bo_event;
			if (bo_event) begin
				bo_phase_out <= bo_sum_w;
			end
		end
	end

	wire logic fine_exceed_w;

	dpcfg_fine_window u_fine (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.enable    (fl_enable_w),
		.limit     (fl_limit_w),
		.phase_err (phase_err),
		.exceed    (fine_exceed_w)
	);

	// any loss cause other than inactivity
	wire logic loss_cause_w;

	assign loss_cause_w = other_loss || fine_exceed_w;

	dpcfg_lock_t lock_q;
	dpcfg_lock_t lock_d;
	logic        lost_d;

	always_comb begin
		lock_d = lock_q;
		case (lock_q)
		DPCFG_LOCKED: begin
			if (!src_active && !noact_loss_w) begin
				lock_d = DPCFG_HOLDING;
			end else if (!src_active || loss_cause_w) begin
				lock_d = DPCFG_LOST;
			end
		end
		// a quiet source holds lock, so phase_lost stays low until inactivity loss is set
		DPCFG_HOLDING: begin
			if (src_active) begin
				lock_d = DPCFG_LOCKED;
			end else if (noact_loss_w) begin
				lock_d = DPCFG_LOST;
			end
		end
		DPCFG_LOST: begin
			if (src_active && !loss_cause_w) begin
				lock_d = DPCFG_LOCKED;
			end
		end
		default: begin
			lock_d = DPCFG_LOST;
		end
		endcase
	end

	assign lost_d = lock_d == DPCFG_LOST;

	wire logic relock_w;
	assign relock_w = lock_q == DPCFG_HOLDING && src_active;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_q     <= DPCFG_LOST;
			phase_lost <= 1'b1;
		end else begin
			lock_q     <= lock_d;
			phase_lost <= lost_d;
		end
	end

	// relock after inactivity is a one-cycle pulse with its correction
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			relock_nearest <= 1'b0;
			relock_adjust  <= 16'h0000;
		end else begin
			relock_nearest <= relock_w;
			// signed full-cycle phase wraps to the nearest edge, +-180 deg
			if (relock_w) begin
				relock_adjust <= dpcfg_negate(phase_err);
			end
		end
	end
endmodule

/* testbench/dpcfg_host.sv */
// host model driving the microprocessor register port
`timescale 1ns/1ps
module dpcfg_host (
	input	wire logic		sys_clk,	// system clock
	output	logic [7:0]		up_addr,	// register address
	output	logic			up_wr,		// write strobe
	output	logic			up_rd,		// read strobe
	output	logic [7:0]		up_wdata,	// write data
	input	wire logic [7:0]	up_rdata	// read data
);
	initial {up_addr, up_wdata, up_wr, up_rd} = 18'h0;
	// offsets kept above -1.4 ns, limit code never 000
	task automatic wr(logic [7:0] a, d);
		@(posedge sys_clk) #1;
		up_addr = a;
		up_wdata = d;
		up_wr = 1;
		@(posedge sys_clk) #1;
		up_wr = 0;
		up_wdata = ~d;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk) #1;
		up_addr = a;
		up_rd = 1;
		@(posedge sys_clk) #1;
		up_rd = 0;
		d = up_rdata;
	endtask
endmodule

/* testbench/dpcfg_properties.sv */
// port-level checks of the offset and phase-loss configuration block
`timescale 1ns/1ps
module dpcfg_properties (
	input	wire logic			sys_clk,
	input	wire logic			resetn,
	input	wire logic [7:0]		up_addr,
	input	wire logic			up_wr,
	input	wire logic			up_rd,
	input	wire logic [7:0]		up_wdata,
	input	wire logic [7:0]		up_rdata,
	input	wire logic			bo_event,
	input	wire dpcfg_pkg::dpcfg_phase_t	bo_phase_in,
	input	wire dpcfg_pkg::dpcfg_phase_t	bo_phase_out,
	input	wire logic			bo_valid,
	input	wire dpcfg_pkg::dpcfg_phase_t	phase_err,
	input	wire logic			src_active,
	input	wire logic			other_loss,
	input	wire logic			phase_lost,
	input	wire logic			relock_nearest,
	input	wire dpcfg_pkg::dpcfg_phase_t	relock_adjust,
	input	wire logic			narrow_test
);
	import dpcfg_pkg::*;
	logic signed [5:0]	off_q;
	logic [7:0]		fl_q;
	logic [1:0]		rc_q;
	default clocking @(posedge sys_clk); endclocking
	// design answers only after its own two-flop reset release
	default disable iff (!rc_q[1]);
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn) {rc_q, off_q, fl_q} <= {2'h0, 6'h00, 8'ha2};
		else begin
			rc_q <= rc_q | {rc_q[0], 1'b1};
			if (up_wr && up_addr == 8'h72) off_q <= up_wdata[5:0];
			if (up_wr && up_addr == 8'h73) fl_q <= up_wdata;
		end
	a_event_valid: assert property (bo_event |=> bo_valid)
		else $error("no valid after event");
	a_valid_cause: assert property (bo_valid |-> $past(bo_event))
		else $error("valid without event");
	a_offset_add: assert property (bo_event |=> bo_phase_out ==
		$past(bo_phase_in) + $past(off_q) * 16'sh10)
		else $error("offset not added");
	a_offset_read: assert property (up_rd && up_addr == 8'h72 |=>
		up_rdata == {2'b00, $past(off_q)}) else $error("offset read");
	a_cfg_read: assert property (up_rd && up_addr == 8'h73 |=>
		up_rdata == $past(fl_q)) else $error("config read");
	a_fine_loss: assert property ((fl_q[7] && src_active &&
		phase_err > $signed({3'b0, fl_q[2:0], 10'h0}))[*3] |=> phase_lost)
		else $error("fine window loss missed");
	a_fine_ignored: assert property ((!fl_q[7] && !fl_q[6] &&
		!other_loss)[*4] ##0 !phase_lost |=> !phase_lost)
		else $error("loss raised without cause");
	a_noact_loss: assert property ((fl_q[6] && !src_active)[*2]
		|=> phase_lost) else $error("inactivity loss missed");
	a_narrow_copy: assert property (narrow_test == $past(fl_q[5]))
		else $error("test bit not mirrored");
	a_relock_adjust: assert property (relock_nearest |->
		relock_adjust == -$past(phase_err)) else $error("relock step wrong");
endmodule
bind dpcfg_top dpcfg_properties u_dpcfg_properties (.*);

/* testbench/tb_top.sv */
// self-checking bench for the offset and phase-loss configuration
`timescale 1ns/1ps
module tb_top;
	import dpcfg_pkg::*;
	logic		sys_clk = 0, resetn = 0, bo_event = 0, up_wr, up_rd;
	logic		src_active = 1, other_loss = 0;
	logic		phase_lost, bo_valid, relock_nearest, narrow_test;
	dpcfg_phase_t	relock_adjust;
	logic [7:0]	up_addr, up_wdata, up_rdata, rd_v;
	dpcfg_phase_t	bo_phase_in = 0, phase_err = 0, bo_phase_out;
	int		errors = 0, compares = 0;
	always #5 sys_clk = ~sys_clk;
	dpcfg_top u_dpcfg_top (.*);
	dpcfg_host u_dpcfg_host (.*);
	task automatic chk(string n, logic [15:0] s, e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rg(logic [7:0] a, e);
		u_dpcfg_host.rd(a, rd_v);
		chk("rdata", {8'h00, rd_v}, {8'h00, e});
	endtask
	task automatic ev(dpcfg_phase_t p, e);
		@(posedge sys_clk) #1;
		bo_event = 1;
		bo_phase_in = p;
		@(posedge sys_clk) #1;
		bo_event = 0;
		chk("valid", {15'h0, bo_valid}, 16'h1);
		chk("phase", bo_phase_out, e);
	endtask
	// bounded wait on phase loss (w=0) or relock pulse (w=1)
	task automatic wt(bit w, logic v);
		for (int i = 0; i < 20 && (w ? relock_nearest : phase_lost) !== v;
			i++) @(posedge sys_clk) #1;
		chk(w ? "relock" : "lost", {15'h0, w ? relock_nearest : phase_lost},
			{15'h0, v});
		if ((w ? relock_nearest : phase_lost) !== v) stop_test();
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 resetn = 1;
		repeat (3) @(posedge sys_clk);
		rg(8'h73, 8'ha2);
		chk("narrow", {15'h0, narrow_test}, 16'h1);
		rg(8'h72, 8'h00);
		ev(16'sd100, 16'sd100);
		u_dpcfg_host.wr(8'h72, 8'hff);
		rg(8'h72, 8'h3f);
		ev(16'sd100, 16'sd84);
		u_dpcfg_host.wr(8'h72, 8'h1f);
		ev(-16'sd5, 16'sd491);
		wt(0, 0);
		phase_err = 16'sh0801;
		wt(0, 1);
		u_dpcfg_host.wr(8'h73, 8'h22);
		wt(0, 0);
		src_active = 0;
		repeat (6) @(posedge sys_clk) #1;
		chk("hold", {15'h0, phase_lost}, 16'h0);
		src_active = 1;
		wt(1, 1);
		chk("adjust", relock_adjust, -16'sh0801);
		u_dpcfg_host.wr(8'h73, 8'h62);
		src_active = 0;
		wt(0, 1);
		src_active = 1;
		wt(0, 0);
		other_loss = 1;
		wt(0, 1);
		stop_test();
	end
endmodule
